/* File: hw/abss_top.sv */
// Abnormal-stop watchdog, quick stop and speed search
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
// Summary of operation
// - An abnormal stop lasting past the time limit without reset or restart turns modulation off and enters the fault state.
// - A programmable S-curve time of zero to five seconds is applied to the quick-stop ramp.
// - Either control word starts a quick stop, which then reports status code 79.
// - Mode bit 2 picks modulation off (0) or holding torque (4) at zero speed after a control-word quick stop.
// - Mode bit 3 keeps the quick-stop status until the function is left (0) or drops it at standstill (8).
// - Without speed search the running motor is first brought to rest before heading for the setpoint.
// - With speed search the present speed is found and the drive ramps from it to the setpoint.
// - The trigger field enables a search after leaving no-release, reset, auto restart or modulation-off standstill, not at power-on, when it is still 0.
// - Over the load limit during a search the frequency falls at 50 to 560 Hz/s chosen by bits 0 to 2.
// - Over the load limit during a search the voltage rises at 0.025 to 0.48 %/ms chosen by bits 3 to 4.
// - Bit 5 sets the load limit to 80 or 130 percent.
// - Bits 6 to 7 choose setpoint, last output, or measured speed with fallback when speed is only calculated.
// - In sensorless vector mode a found speed below the low limit is replaced by zero.
module abss_top
    import abss_pkg::*;
#(
    parameter int TICK_LEN = abss_pkg::TICK_CYCLES
)(
    input  wire logic               sys_clk,
    input  wire logic               sys_rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    output logic                    irq,
    input  wire logic               control_word_a,
    input  wire logic               control_word_b,
    input  wire logic               abn_stop_active,
    input  wire logic               fault_reset,
    input  wire logic               auto_restart,
    input  wire logic               at_standstill,
    input  wire logic               no_control_release_state,
    input  wire logic               modulation_off_standstill,
    input  wire logic               speed_source_select,
    input  wire logic               sensorless_vector_mode,
    input  wire logic               search_done,
    input  wire logic signed [15:0] speed_setpoint,
    input  wire logic signed [15:0] last_output_freq,
    input  wire logic signed [15:0] measured_speed,
    input  wire logic signed [15:0] found_speed,
    input  wire logic [7:0]         load_pct,
    output logic                    modulation_on,
    output logic                    holding_torque,
    output logic                    abnormal_stop_state,
    output logic                    fault_state,
    output logic [7:0]              status_code,
    output logic [15:0]             scurve_time,
    output logic                    brake_first,
    output logic                    search_active,
    output logic signed [15:0]      search_start,
    output logic signed [15:0]      search_result,
    output logic                    over_load,
    output logic [9:0]              freq_reduce_rate,
    output logic [8:0]              volt_rise_rate,
    output logic [7:0]              load_limit
);
    import abss_pkg::*;

    typedef enum logic [1:0] { QS_IDLE, QS_RAMP, QS_REST } abss_qs_t;
    typedef enum logic [1:0] { SS_IDLE, SS_BRAKE, SS_SEARCH } abss_ss_t;

    logic [4:0]         qs_mode_reg;
    logic [15:0]        abn_limit_reg;
    logic [15:0]        scurve_reg;
    logic [4:0]         ss_trig_reg;
    logic [7:0]         ss_mode_reg;
    logic signed [15:0] ss_low_reg;
    logic [2:0]         irq_stat_reg;
    logic [2:0]         irq_mask_reg;
    logic [2:0]         irq_stat_next;
    abss_qs_t           qs_reg;
    abss_ss_t           ss_reg;
    logic [31:0]        tick_cnt_reg;
    logic [15:0]        abn_cnt_reg;
    logic               abn_prev_reg;
    logic               qs_req_prev_reg;
    logic               ncr_prev_reg;
    logic               ls_prev_reg;
    logic               pon_reg;
    logic               tick;
    logic               qs_req;
    logic               start_evt;
    logic               trig_hit;
    logic [2:0]         events;
    logic               wr_acc;
    logic               rd_acc;
    logic               setup;
    logic               mapped;
    logic [31:0]        rd_data;
    logic [15:0]        wval;

    // ====
    // APB slave, no wait states
    assign setup  = psel && !penable && !pready;
    assign wr_acc = psel && penable && pready && pwrite && !pslverr;
    assign rd_acc = psel && penable && pready && !pwrite && !pslverr;
    assign wval   = pwdata[15:0];

    always_comb
    begin
        mapped  = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (paddr)
            QS_MODE_OFS:   rd_data[4:0]  = qs_mode_reg;
            ABN_LIMIT_OFS: rd_data[15:0] = abn_limit_reg;
            SCURVE_OFS:    rd_data[15:0] = scurve_reg;
            SS_TRIG_OFS:   rd_data[4:0]  = ss_trig_reg;
            SS_MODE_OFS:   rd_data[7:0]  = ss_mode_reg;
            SS_LOW_OFS:    rd_data[15:0] = ss_low_reg;
            IRQ_STAT_OFS:  rd_data[2:0]  = irq_stat_reg;
            IRQ_MASK_OFS:  rd_data[2:0]  = irq_mask_reg;
            STATE_OFS:     rd_data[15:0] = {abn_cnt_reg[11:0],
                               fault_state, abnormal_stop_state,
                               search_active, modulation_on};
            default:       mapped = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup)
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    // ====
    // Configuration registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            qs_mode_reg   <= QS_MODE_RST;
            abn_limit_reg <= ABN_LIMIT_RST;
            scurve_reg    <= SCURVE_RST;
            ss_trig_reg   <= SS_TRIG_RST;
            ss_mode_reg   <= SS_MODE_RST;
            ss_low_reg    <= SS_LOW_RST;
            irq_mask_reg  <= IRQ_MASK_RST;
        end
        else if (wr_acc)
        begin
            unique case (paddr)
                QS_MODE_OFS:   qs_mode_reg <= pwdata[4:0];
                ABN_LIMIT_OFS: abn_limit_reg <=
                    (wval > ABN_LIMIT_MAX) ? ABN_LIMIT_MAX :
                    (wval < ABN_LIMIT_MIN) ? ABN_LIMIT_MIN : wval;
                SCURVE_OFS:    scurve_reg <=
                    (wval > SCURVE_MAX) ? SCURVE_MAX : wval;
                SS_TRIG_OFS:   ss_trig_reg <= pwdata[4:0];
                SS_MODE_OFS:   ss_mode_reg <= pwdata[7:0];
                SS_LOW_OFS:    ss_low_reg <=
                    ($signed(wval) > SS_LOW_MAX) ? SS_LOW_MAX :
                    ($signed(wval) < -SS_LOW_MAX) ? -SS_LOW_MAX :
                    $signed(wval);
                IRQ_MASK_OFS:  irq_mask_reg <= pwdata[2:0];
                default:       ;
            endcase
        end
    end

    // ====
    // Interrupt status
    assign events[IRQ_QS_BIT]    = start_evt;
    assign events[IRQ_FAULT_BIT] = tick && abnormal_stop_state &&
                                   abn_cnt_reg + 16'h0001 >= abn_limit_reg;
    assign events[IRQ_SS_BIT]    = (ss_reg == SS_SEARCH) && search_done;

    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (rd_acc && paddr == IRQ_STAT_OFS)
            irq_stat_next = 3'h0;
        irq_stat_next = irq_stat_next | events;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            irq_stat_reg <= 3'h0;
            irq          <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            irq          <= |(irq_stat_next & irq_mask_reg);
        end
    end

    // ====
    // 10 ms tick
    assign tick = (tick_cnt_reg == 32'(TICK_LEN - 1));

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || (abn_stop_active && !abn_prev_reg) || tick)
            tick_cnt_reg <= 32'h0000_0000;
        else
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end

    // ====
    // Abnormal-stop watchdog
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            abn_prev_reg        <= 1'b0;
            abn_cnt_reg         <= 16'h0000;
            abnormal_stop_state <= 1'b0;
            fault_state         <= 1'b0;
        end
        else
        begin
            abn_prev_reg <= abn_stop_active;
            if (fault_reset || auto_restart)
            begin
                abn_cnt_reg         <= 16'h0000;
                abnormal_stop_state <= 1'b0;
                fault_state         <= 1'b0;
            end
            else if (abn_stop_active && !abn_prev_reg)
            begin
                abn_cnt_reg         <= 16'h0000;
                abnormal_stop_state <= !fault_state;
            end
            else if (events[IRQ_FAULT_BIT])
            begin
                abnormal_stop_state <= 1'b0;
                fault_state         <= 1'b1;
            end
            else if (abnormal_stop_state && tick)
                abn_cnt_reg <= abn_cnt_reg + 16'h0001;
        end
    end

    // ====
    // Quick stop via control word
    assign qs_req    = control_word_a || control_word_b;
    assign start_evt = qs_req && !qs_req_prev_reg && !fault_state;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            qs_req_prev_reg <= 1'b0;
            qs_reg          <= QS_IDLE;
        end
        else
        begin
            qs_req_prev_reg <= qs_req;
            unique case (qs_reg)
                QS_IDLE:
                    if (start_evt)
                        qs_reg <= QS_RAMP;
                QS_RAMP:
                    if (!qs_req)
                        qs_reg <= QS_IDLE;
                    else if (at_standstill)
                        qs_reg <= QS_REST;
                QS_REST:
                    if (!qs_req)
                        qs_reg <= QS_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            modulation_on  <= 1'b0;
            holding_torque <= 1'b0;
            status_code    <= 8'h00;
            scurve_time    <= SCURVE_RST;
        end
        else
        begin
            scurve_time   <= (qs_reg == QS_RAMP) ? scurve_reg
                                                  : SCURVE_RST;
            modulation_on <= !fault_state && !(qs_reg == QS_REST &&
                             !qs_mode_reg[QS_HOLD_BIT]);
            holding_torque <= qs_reg == QS_REST &&
                              qs_mode_reg[QS_HOLD_BIT];
            status_code <= (qs_reg == QS_RAMP ||
                            (qs_reg == QS_REST &&
                             !qs_mode_reg[QS_CLR_BIT]))
                           ? QS_STATUS_CODE : 8'h00;
        end
    end

    // ====
    // Speed search
    always_comb
    begin
        trig_hit = 1'b0;
        if (ss_trig_reg[TRIG_NCR_BIT] && ncr_prev_reg &&
            !no_control_release_state)
            trig_hit = 1'b1;
        if (ss_trig_reg[TRIG_PON_BIT] && pon_reg)
            trig_hit = 1'b1;
        if (ss_trig_reg[TRIG_RST_BIT] && fault_reset)
            trig_hit = 1'b1;
        if (ss_trig_reg[TRIG_AUTO_BIT] && auto_restart)
            trig_hit = 1'b1;
        if (ss_trig_reg[TRIG_LS_BIT] && ls_prev_reg &&
            !modulation_off_standstill)
            trig_hit = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pon_reg       <= 1'b1;
            ncr_prev_reg  <= 1'b0;
            ls_prev_reg   <= 1'b0;
            ss_reg        <= SS_IDLE;
            brake_first   <= 1'b0;
            search_active <= 1'b0;
            search_start  <= 16'sh0000;
            search_result <= 16'sh0000;
        end
        else
        begin
            pon_reg      <= 1'b0;
            ncr_prev_reg <= no_control_release_state;
            ls_prev_reg  <= modulation_off_standstill;
            unique case (ss_reg)
                SS_IDLE:
                    if (ncr_prev_reg && !no_control_release_state &&
                        !trig_hit && !at_standstill)
                    begin
                        ss_reg      <= SS_BRAKE;
                        brake_first <= 1'b1;
                    end
                    else if (trig_hit)
                    begin
                        ss_reg        <= SS_SEARCH;
                        search_active <= 1'b1;
                        unique case (abss_src_t'(ss_mode_reg[START_LSB +: 2]))
                            SRC_SETPOINT:  search_start <= speed_setpoint;
                            SRC_LAST:      search_start <= last_output_freq;
                            SRC_MEAS_SET:  search_start <=
                                speed_source_select ? speed_setpoint
                                                    : measured_speed;
                            SRC_MEAS_LAST: search_start <=
                                speed_source_select ? last_output_freq
                                                    : measured_speed;
                        endcase
                    end
                SS_BRAKE:
                    if (at_standstill)
                    begin
                        ss_reg      <= SS_IDLE;
                        brake_first <= 1'b0;
                    end
                SS_SEARCH:
                    if (search_done)
                    begin
                        ss_reg        <= SS_IDLE;
                        search_active <= 1'b0;
                        search_result <= (sensorless_vector_mode &&
                                          found_speed < ss_low_reg)
                                         ? 16'sh0000 : found_speed;
                    end
                default:
                    ss_reg <= SS_IDLE;
            endcase
        end
    end

    // ====
    // Load limit and rates
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            load_limit       <= LOAD_LO_PCT;
            over_load        <= 1'b0;
            freq_reduce_rate <= 10'h000;
            volt_rise_rate   <= 9'h000;
        end
        else
        begin
            load_limit <= ss_mode_reg[LOAD_BIT] ? LOAD_HI_PCT
                                                : LOAD_LO_PCT;
            over_load  <= search_active && load_pct > load_limit;
            unique case (ss_mode_reg[FRED_LSB +: 3])
                3'h0: freq_reduce_rate <= 10'h032;
                3'h1: freq_reduce_rate <= 10'h046;
                3'h2: freq_reduce_rate <= 10'h064;
                3'h3: freq_reduce_rate <= 10'h096;
                3'h4: freq_reduce_rate <= 10'h0C8;
                3'h5: freq_reduce_rate <= 10'h118;
                3'h6: freq_reduce_rate <= 10'h190;
                3'h7: freq_reduce_rate <= 10'h230;
            endcase
            unique case (ss_mode_reg[VRISE_LSB +: 2])
                2'h0: volt_rise_rate <= 9'h019;
                2'h1: volt_rise_rate <= 9'h078;
                2'h2: volt_rise_rate <= 9'h0F0;
                2'h3: volt_rise_rate <= 9'h1E0;
            endcase
        end
    end
endmodule

/* File: hw/abss_pkg.sv */
// Supervisor constants
package abss_pkg;
    // ====
    // Register byte offsets
    localparam logic [7:0] QS_MODE_OFS    = 8'h00;
    localparam logic [7:0] ABN_LIMIT_OFS  = 8'h04;
    localparam logic [7:0] SCURVE_OFS     = 8'h08;
    localparam logic [7:0] SS_TRIG_OFS    = 8'h0C;
    localparam logic [7:0] SS_MODE_OFS    = 8'h10;
    localparam logic [7:0] SS_LOW_OFS     = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h1C;
    localparam logic [7:0] STATE_OFS      = 8'h20;
    // ====
    // Reset values
    localparam logic [4:0]  QS_MODE_RST   = 5'h00;
    localparam logic [15:0] ABN_LIMIT_RST = 16'h2710;
    localparam logic [15:0] SCURVE_RST    = 16'h0000;
    localparam logic [4:0]  SS_TRIG_RST   = 5'h00;
    localparam logic [7:0]  SS_MODE_RST   = 8'h00;
    localparam logic [15:0] SS_LOW_RST    = 16'h0000;
    localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;
    // ====
    // Field positions
    localparam int QS_HOLD_BIT    = 2;
    localparam int QS_CLR_BIT     = 3;
    localparam int TRIG_NCR_BIT   = 0;
    localparam int TRIG_PON_BIT   = 1;
    localparam int TRIG_RST_BIT   = 2;
    localparam int TRIG_AUTO_BIT  = 3;
    localparam int TRIG_LS_BIT    = 4;
    localparam int FRED_LSB       = 0;
    localparam int VRISE_LSB      = 3;
    localparam int LOAD_BIT       = 5;
    localparam int START_LSB      = 6;
    localparam int IRQ_QS_BIT     = 0;
    localparam int IRQ_FAULT_BIT  = 1;
    localparam int IRQ_SS_BIT     = 2;
    // ====
    // Limits, codes and timing
    localparam logic [15:0] ABN_LIMIT_MAX = 16'h2710;
    localparam logic [15:0] ABN_LIMIT_MIN = 16'h0001;
    localparam logic [15:0] SCURVE_MAX    = 16'h01F4;
    localparam logic signed [15:0] SS_LOW_MAX = 16'sh00C8;
    localparam logic [7:0]  QS_STATUS_CODE = 8'h4F;
    localparam logic [7:0]  LOAD_LO_PCT   = 8'h50;
    localparam logic [7:0]  LOAD_HI_PCT   = 8'h82;
    localparam int TICK_TIME_US    = 10000;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TICK_CYCLES     =
        (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
    typedef enum logic [1:0] { SRC_SETPOINT, SRC_MEAS_SET,
                               SRC_LAST, SRC_MEAS_LAST } abss_src_t;
endpackage

/* File: tb/abss_chk_sva.sv */
// Supervisor port checker
`timescale 1ns/1ns
module abss_chk
    import abss_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        control_word_a,
    input wire logic        control_word_b,
    input wire logic        at_standstill,
    input wire logic        search_done,
    input wire logic        search_active,
    input wire logic        fault_state,
    input wire logic        modulation_on,
    input wire logic [7:0]  status_code,
    input wire logic [15:0] scurve_time,
    input wire logic        brake_first,
    input wire logic [9:0]  freq_reduce_rate,
    input wire logic [8:0]  volt_rise_rate,
    input wire logic [7:0]  load_limit
);
    localparam logic [9:0] FRT [8] = '{10'h032, 10'h046, 10'h064, 10'h096,
                                      10'h0C8, 10'h118, 10'h190, 10'h230};
    localparam logic [8:0] VRT [4] = '{9'h019, 9'h078, 9'h0F0, 9'h1E0};
    logic [7:0] mode_q;
    logic [1:0] settle;
    logic       wr;
    assign wr = psel && penable && pready && pwrite && paddr == SS_MODE_OFS;
    // ====
    // Search mode shadow
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mode_q <= 8'h00;
        else if (wr)
            mode_q <= pwdata[7:0];
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || wr)
            settle <= 2'h0;
        else if (settle != 2'h3)
            settle <= settle + 2'h1;
    end
    // ====
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready");
    chk_qs_code: assert property (!fault_state &&
        $rose(control_word_a | control_word_b) |-> ##2 status_code == 8'h4F)
        else $error("no qs code");
    chk_fault_modoff: assert property ($rose(fault_state)
        |-> ##[0:1] !modulation_on) else $error("mod in fault");
    chk_fred_rate: assert property (settle == 2'h3
        |-> freq_reduce_rate == FRT[mode_q[2:0]]) else $error("bad fred");
    chk_volt_rate: assert property (settle == 2'h3
        |-> volt_rise_rate == VRT[mode_q[4:3]]) else $error("bad vrise");
    chk_load_sel: assert property (settle == 2'h3 |-> load_limit ==
        (mode_q[5] ? LOAD_HI_PCT : LOAD_LO_PCT)) else $error("bad load");
    chk_scurve_max: assert property (scurve_time <= SCURVE_MAX)
        else $error("scurve high");
    chk_brake_end: assert property (brake_first && at_standstill
        |-> ##[1:2] !brake_first) else $error("brake kept");
    chk_search_end: assert property (search_active && search_done
        |=> !search_active) else $error("search kept");
    cover property (status_code == QS_STATUS_CODE);
    cover property ($rose(fault_state));
    cover property (search_done);
endmodule
bind abss_top abss_chk i_chk (.*);

/* File: tb/abss_motor.sv */
// Motor stand-in
`timescale 1ns/1ns
module abss_motor
    import abss_pkg::*;
#(
    parameter int LAT = 3
)(
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    input  wire logic          search_active,
    input  wire logic          brake_first,
    input  wire logic [7:0]    status_code,
    output logic               at_standstill,
    output logic               search_done,
    output logic signed [15:0] found_speed
);
    logic [3:0] cnt;
    logic       ramp;
    assign ramp = brake_first || status_code == QS_STATUS_CODE;
    // ====
    // Spin-down time
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !(ramp || search_active))
            cnt <= 4'h0;
        else if (cnt != 4'hF)
            cnt <= cnt + 4'h1;
    end
    // Speed valid with done
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            search_done <= 1'b0;
        else
            search_done <= search_active && cnt == 4'(LAT);
        at_standstill <= !sys_rst && ramp && cnt >= 4'(LAT);
        found_speed <= search_active && cnt == 4'(LAT) ? 16'sh0032
                                                       : ~found_speed;
    end
endmodule

/* File: tb/abnormal_stop_and_speed_search_bench.sv */
// Supervisor bench
`timescale 1ns/1ns
module abnormal_stop_and_speed_search_bench;
    import abss_pkg::*;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic control_word_a, control_word_b, abn_stop_active, fault_reset;
    logic auto_restart, at_standstill, no_control_release_state;
    logic modulation_off_standstill, speed_source_select, search_done;
    logic sensorless_vector_mode, modulation_on, holding_torque, over_load;
    logic abnormal_stop_state, fault_state, brake_first, search_active;
    logic signed [15:0] speed_setpoint, last_output_freq, measured_speed;
    logic signed [15:0] found_speed, search_start, search_result;
    logic [7:0]  paddr, status_code, load_limit, load_pct;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] scurve_time;
    logic [9:0]  freq_reduce_rate;
    logic [8:0]  volt_rise_rate;
    int          errors, checks, n;
    abss_top #(.TICK_LEN(4)) i_dut (.*);
    abss_motor i_motor (.*);
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // ====
    // Shared tasks
    task automatic cmp(input string nm, input logic [31:0] x, g);
        checks++;
        if (g !== x)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge sys_clk); while (pready !== 1'b1 && n++ < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ====
    // Scenarios
    task automatic t_regs;
        apb(1'b0, ABN_LIMIT_OFS, 32'h0);
        cmp("limit reset", {16'h0, ABN_LIMIT_RST}, rd);
        apb(1'b1, SCURVE_OFS, 32'h300);
        apb(1'b0, SCURVE_OFS, 32'h0);
        cmp("scurve", {16'h0, SCURVE_MAX}, rd);
        apb(1'b0, 8'h24, 32'h0);
        cmp("unmapped", 32'h1, e);
        apb(1'b1, IRQ_MASK_OFS, 32'h7);
        $display("test regs done");
    endtask
    task automatic t_qs(input logic wb, input logic [31:0] mode);
        apb(1'b1, QS_MODE_OFS, mode);
        @(posedge sys_clk);
        control_word_a <= !wb;
        control_word_b <= wb;
        repeat (3) @(negedge sys_clk);
        cmp("qs code", 32'h4F, status_code);
        cmp("ramp s", 32'h1F4, scurve_time);
        n = 0;
        while (at_standstill !== 1'b1 && n++ < 50) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        cmp("hold", mode[2], holding_torque);
        cmp("mod on", mode[2], modulation_on);
        cmp("qs rest", mode[3] ? 32'h0 : 32'h4F, status_code);
        cmp("irq on", 32'h1, irq);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        cmp("irq stat", 32'h1, rd);
        @(posedge sys_clk);
        control_word_a <= 1'b0;
        control_word_b <= 1'b0;
        repeat (3) @(negedge sys_clk);
        cmp("irq clear", 32'h0, irq);
        cmp("qs left", 32'h0, status_code);
        $display("test qs done");
    endtask
    task automatic t_fault;
        apb(1'b1, ABN_LIMIT_OFS, 32'h2);
        @(posedge sys_clk);
        abn_stop_active <= 1'b1;
        n = 0;
        while (fault_state !== 1'b1 && n++ < 100) @(negedge sys_clk);
        cmp("fault time", 32'h1, n < 12);
        cmp("abn left", 32'h0, abnormal_stop_state);
        @(negedge sys_clk);
        cmp("mod off", 32'h0, modulation_on);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        cmp("irq fault", 32'h2, rd);
        @(posedge sys_clk);
        abn_stop_active <= 1'b0;
        auto_restart <= 1'b1;
        @(posedge sys_clk);
        auto_restart <= 1'b0;
        repeat (2) @(negedge sys_clk);
        cmp("fault", 32'h0, fault_state);
        $display("test fault done");
    endtask
    task automatic t_search;
        apb(1'b1, SS_LOW_OFS, 32'h64);
        apb(1'b1, SS_MODE_OFS, 32'hBD);
        apb(1'b1, SS_TRIG_OFS, 32'h1);
        @(posedge sys_clk);
        no_control_release_state <= 1'b0;
        n = 0;
        while (search_active !== 1'b1 && n++ < 20) @(negedge sys_clk);
        cmp("start", 32'h12C, search_start);
        cmp("fred", 32'h118, freq_reduce_rate);
        cmp("vrise", 32'h1E0, volt_rise_rate);
        cmp("load", 32'h82, load_limit);
        cmp("over load", 32'h0, over_load);
        n = 0;
        while (search_active !== 1'b0 && n++ < 20) @(negedge sys_clk);
        cmp("result", 32'h0, search_result);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        cmp("irq ss", 32'h4, rd);
        apb(1'b1, SS_TRIG_OFS, 32'h0);
        no_control_release_state <= 1'b1;
        @(posedge sys_clk);
        no_control_release_state <= 1'b0;
        n = 0;
        while (brake_first !== 1'b1 && n++ < 5) @(negedge sys_clk);
        cmp("brake", 32'h1, brake_first);
        cmp("no search", 32'h0, search_active);
        $display("test search done");
    endtask
    // ====
    // Main sequence and watchdog
    initial
    begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = 0;
        {control_word_a, control_word_b, abn_stop_active, fault_reset} = 0;
        {auto_restart, modulation_off_standstill, speed_source_select} = 0;
        {speed_setpoint, measured_speed} = 0;
        load_pct = 8'h64;
        last_output_freq = 16'sh012C;
        sensorless_vector_mode = 1'b1;
        no_control_release_state = 1'b1;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_qs(1'b1, 32'h4);
        t_qs(1'b0, 32'h8);
        t_fault();
        t_search();
        end_sim();
    end
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
endmodule
